// [rtl/analog_die_cfg.svh]
// Register map, field positions and constants of the analog die control.
`ifndef ANALOG_DIE_CFG_SVH
`define ANALOG_DIE_CFG_SVH

// ---------------------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------------------
`define ADDR_SYSTEM_CONTROL 5'h03
`define ADDR_INTERRUPT_MASK 5'h04
`define ADDR_INTERRUPT_FLAG 5'h05
`define ADDR_RESET_MASK 5'h06
`define ADDR_DIAG_MUX 5'h07
`define ADDR_POWER_OUTPUT 5'h0b
`define ADDR_SYSTEM_STATUS 5'h0c

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define BIT_SUPPLY_ON 7
`define BIT_BUS_WAKE_IE 5
`define BIT_BUS_EDGE_FLAG 5
`define BIT_OVERTEMP_TEST 7
`define BIT_OVERVOLT_RE 1
`define BIT_OVERTEMP_RE 0
`define BIT_CURRENT_LIMIT 6
`define BIT_CS_ON 2
`define BIT_CS_LEVEL_LO 4
`define BIT_CS_LEVEL_HI 5
`define MUX_SEL_HI 3

// ---------------------------------------------------------------------------
// Reset value and serial frame layout
// ---------------------------------------------------------------------------
`define REG_RESET 8'h00
`define HDR_RW_BIT 7
`define HDR_ADDR_HI 6
`define HDR_ADDR_LO 2
`define HDR_PARITY_BIT 1
`define FRAME_HDR_BITS 5'h08
`define FRAME_ALL_BITS 5'h10

// ---------------------------------------------------------------------------
// Multiplexer codes and current source levels
// ---------------------------------------------------------------------------
`define MUX_CODE_UNUSED 3'h6
`define CS_PCT_00 7'h0a
`define CS_PCT_01 7'h1e
`define CS_PCT_10 7'h3c
`define CS_PCT_11 7'h64

`endif

// [rtl/analog_die_pkg.sv]
// Types shared by the analog die control modules.
package analog_die_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] reg_addr_t;
  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_HEADER,
    FRAME_DATA,
    FRAME_OVER
  } frame_state_t;
endpackage : analog_die_pkg

// [rtl/bit_sync.sv]
// Two flip-flop synchroniser, one chain per bit.
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("bit_sync needs at least one bit");
  end

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic first_stage;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        first_stage <= INIT[i];
        sync_out[i] <= INIT[i];
      end else begin
        first_stage <= async_in[i];
        sync_out[i] <= first_stage;
      end
    end
  end
endmodule : bit_sync

// [rtl/serial_reg_slave.sv]
// Serial register slave: header byte, data byte, write on select release.
`timescale 1ns/1ps
`include "analog_die_cfg.svh"
module serial_reg_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire analog_die_pkg::reg_byte_t status_byte,
  input wire analog_die_pkg::reg_byte_t read_data,
  output analog_die_pkg::reg_addr_t read_addr,
  output logic wr_en,
  output analog_die_pkg::reg_addr_t wr_addr,
  output analog_die_pkg::reg_byte_t wr_data
);
  analog_die_pkg::frame_state_t state;
  analog_die_pkg::reg_byte_t rx_shift;
  analog_die_pkg::reg_byte_t tx_shift;
  analog_die_pkg::reg_byte_t header;
  logic [4:0] bit_cnt;
  logic ss_q;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  logic parity_ok;

  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign ss_fall = ~ss_n & ss_q;
  assign ss_rise = ss_n & ~ss_q;
  assign read_addr = header[`HDR_ADDR_HI:`HDR_ADDR_LO];
  // Parity covers the direction bit and the address: even count gives 0.
  assign parity_ok = (^header[`HDR_RW_BIT:`HDR_ADDR_LO]) ==
                     header[`HDR_PARITY_BIT];
  assign miso = tx_shift[7];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ss_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      ss_q <= ss_n;
      sclk_q <= sclk;
    end
  end

  // -------------------------------------------------------------------------
  // Frame sequencing
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= analog_die_pkg::FRAME_IDLE;
      bit_cnt <= 5'h00;
      rx_shift <= `REG_RESET;
      header <= `REG_RESET;
    end else if (ss_fall) begin
      state <= analog_die_pkg::FRAME_HEADER;
      bit_cnt <= 5'h00;
    end else if (ss_rise) begin
      state <= analog_die_pkg::FRAME_IDLE;
    end else if (sclk_rise && !ss_n) begin
      rx_shift <= {rx_shift[6:0], mosi};
      unique case (state)
        analog_die_pkg::FRAME_IDLE: begin
        end
        analog_die_pkg::FRAME_HEADER: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `FRAME_HDR_BITS - 5'h01) begin
            header <= {rx_shift[6:0], mosi};
            state <= analog_die_pkg::FRAME_DATA;
          end
        end
        analog_die_pkg::FRAME_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `FRAME_ALL_BITS - 5'h01) begin
            state <= analog_die_pkg::FRAME_OVER;
          end
        end
        analog_die_pkg::FRAME_OVER: begin
          // Extra clocks past the data byte leave the frame unusable.
          state <= analog_die_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  // The status byte goes out first, then the addressed register as it
  // stood before any write of this frame.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_shift <= `REG_RESET;
    end else if (ss_fall) begin
      tx_shift <= status_byte;
    end else if (sclk_fall && !ss_n) begin
      if (bit_cnt == `FRAME_HDR_BITS) begin
        tx_shift <= read_data;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_en <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= `REG_RESET;
    end else begin
      wr_en <= ss_rise && state == analog_die_pkg::FRAME_OVER &&
               !header[`HDR_RW_BIT] && parity_ok; // R21
      wr_addr <= read_addr;
      wr_data <= rx_shift;
    end
  end
endmodule : serial_reg_slave

// [rtl/analog_die_ctrl.sv]
// Reset, bus transceiver, diagnostic mux and current source control.
//
// What this block does
// R1: Overvoltage with its reset enable set pulls the reset pin low.
// R2: Every reset leaves the overvoltage reset source disabled.
// R3: A low level on the shared reset pin resets all logic except the pin synchronisers.
// R4: Reset mask bit 1 enables the overvoltage reset, read/write.
// R5: Reset mask bit 0 enables the overtemperature reset; reset clears it.
// R6: Reset mask bit 7 selects the lowered test overtemperature threshold.
// R7: Bus transmitter is enabled only while the supply on bit is set.
// R8: Transmitter in current limitation sets the status current limit bit.
// R9: Host software should turn the transmitter off when limit bit sets.
// R10: Bus driven dominant while transmit input low, released while high.
// R11: An undriven transmit input counts as high, keeping bus recessive.
// R12: Receive output follows the bus: high recessive, low dominant.
// R13: Stop mode disables the transmitter; receiver stays active.
// R14: With wake enable set, a bus falling edge interrupts and wakes.
// R15: Four-bit select routes current senses, prescaler, sensor, aux input.
// R16: Reset clears the select field; upper four bits read zero.
// R17: Current source on only with supply on and source enable both set.
// R18: Two-bit level picks 10, 30, 60 or 100 percent.
// R19: Stop mode switches the current source off regardless of settings.
// R20: Bus edge flag sets per falling edge; write one clears it.
// R21: Write data is latched at the rising edge of slave select.
// R22: Unused select codes route nothing but still read back.
`timescale 1ns/1ps
`include "analog_die_cfg.svh"
module analog_die_ctrl #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_ss_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic supply_overvoltage,
  input wire logic overtemp,
  output logic overtemp_low_threshold,
  input wire logic stop_mode,
  input wire logic txd,
  output logic rxd,
  input wire logic lin_in,
  output logic lin_out,
  output logic lin_oe_n,
  input wire logic lin_current_limit,
  output logic lin_wake_irq,
  output logic regulator_wake,
  output logic [CHANNELS-1:0] diag_channel_en,
  output logic current_source_en,
  output logic [6:0] current_source_pct
);
  if (CHANNELS != 8) begin : g_bad_channels
    $error("analog_die_ctrl decodes exactly eight mux channels");
  end

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  logic [9:0] pins_async;
  logic [9:0] pins_sync;
  logic ss_n_s;
  logic sclk_s;
  logic mosi_s;
  logic rst_pin_s;
  logic overvolt_s;
  logic overtemp_s;
  logic stop_s;
  logic txd_s;
  logic lin_s;
  logic limit_s;

  assign pins_async = {spi_ss_n, spi_sclk, spi_mosi, rst_pin_in,
                       supply_overvoltage, overtemp, stop_mode, txd,
                       lin_in, lin_current_limit};
  assign {ss_n_s, sclk_s, mosi_s, rst_pin_s, overvolt_s, overtemp_s,
          stop_s, txd_s, lin_s, limit_s} = pins_sync;

  // Idle levels: select high, reset pin high, transmit input high and bus
  // recessive, so nothing spurious happens in the cycles after reset.
  bit_sync #(
    .WIDTH(10),
    .INIT(10'h246)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  // -------------------------------------------------------------------------
  // Logic reset
  // -------------------------------------------------------------------------
  logic logic_rst;

  // The pin is shared, so a reset that this block drives itself also lands
  // here and clears the enable that caused it; the pin then lets go.
  assign logic_rst = rst | ~rst_pin_s; // R3

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic supply_on;
  logic bus_wake_interrupt_enable;
  logic bus_falling_edge_flag;
  logic overtemp_threshold_test;
  logic overvoltage_reset_enable;
  logic overtemp_reset_enable;
  logic [`MUX_SEL_HI:0] mux_select;
  logic current_source_on;
  logic [1:0] current_level_sel;
  logic lin_q;
  logic bus_fall;

  logic wr_en;
  analog_die_pkg::reg_addr_t wr_addr;
  analog_die_pkg::reg_byte_t wr_data;
  analog_die_pkg::reg_addr_t rd_addr;
  analog_die_pkg::reg_byte_t rd_data;
  analog_die_pkg::reg_byte_t status_byte;

  serial_reg_slave u_slave (
    .ref_clk(ref_clk),
    .rst(logic_rst),
    .ss_n(ss_n_s),
    .sclk(sclk_s),
    .mosi(mosi_s),
    .miso(spi_miso),
    .status_byte(status_byte),
    .read_data(rd_data),
    .read_addr(rd_addr),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      supply_on <= 1'b0;
    end else if (wr_en && wr_addr == `ADDR_SYSTEM_CONTROL) begin
      supply_on <= wr_data[`BIT_SUPPLY_ON];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      bus_wake_interrupt_enable <= 1'b0;
    end else if (wr_en && wr_addr == `ADDR_INTERRUPT_MASK) begin
      bus_wake_interrupt_enable <= wr_data[`BIT_BUS_WAKE_IE];
    end
  end

  // Reset mask: both reset sources come up disabled after any reset.
  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      overtemp_threshold_test <= 1'b0;
      overvoltage_reset_enable <= 1'b0; // R2
      overtemp_reset_enable <= 1'b0; // R5
    end else if (wr_en && wr_addr == `ADDR_RESET_MASK) begin
      overtemp_threshold_test <= wr_data[`BIT_OVERTEMP_TEST]; // R6
      overvoltage_reset_enable <= wr_data[`BIT_OVERVOLT_RE]; // R4
      overtemp_reset_enable <= wr_data[`BIT_OVERTEMP_RE]; // R5
    end
  end

  // Every code is stored, used or not, so software reads back its write.
  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      mux_select <= 4'h0; // R16
    end else if (wr_en && wr_addr == `ADDR_DIAG_MUX) begin
      mux_select <= wr_data[`MUX_SEL_HI:0]; // R22
    end
  end

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      current_source_on <= 1'b0;
      current_level_sel <= 2'h0;
    end else if (wr_en && wr_addr == `ADDR_POWER_OUTPUT) begin
      current_source_on <= wr_data[`BIT_CS_ON];
      current_level_sel <= wr_data[`BIT_CS_LEVEL_HI:`BIT_CS_LEVEL_LO];
    end
  end

  // -------------------------------------------------------------------------
  // Bus edge flag
  // -------------------------------------------------------------------------
  // The receiver runs in stop mode too, so edges are seen while asleep.
  assign bus_fall = lin_q & ~lin_s; // R13

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      lin_q <= 1'b1;
    end else begin
      lin_q <= lin_s;
    end
  end

  // A falling edge in the same cycle as a clearing write keeps the flag.
  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      bus_falling_edge_flag <= 1'b0;
    end else if (bus_fall) begin
      bus_falling_edge_flag <= 1'b1; // R20
    end else if (wr_en && wr_addr == `ADDR_INTERRUPT_FLAG &&
                 wr_data[`BIT_BUS_EDGE_FLAG]) begin
      bus_falling_edge_flag <= 1'b0; // R20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      lin_wake_irq <= 1'b0;
      regulator_wake <= 1'b0;
    end else begin
      lin_wake_irq <= bus_falling_edge_flag & bus_wake_interrupt_enable; // R14
      regulator_wake <= bus_falling_edge_flag &
                        bus_wake_interrupt_enable; // R14
    end
  end

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  // The limit bit mirrors the live condition; software is expected to drop
  // the supply on bit as soon as it sees it, the driver has no timeout.
  always_comb begin
    status_byte = `REG_RESET;
    status_byte[`BIT_CURRENT_LIMIT] = limit_s & supply_on; // R8 R9
  end

  always_comb begin
    rd_data = `REG_RESET;
    unique case (rd_addr)
      `ADDR_SYSTEM_CONTROL: rd_data[`BIT_SUPPLY_ON] = supply_on;
      `ADDR_INTERRUPT_MASK: begin
        rd_data[`BIT_BUS_WAKE_IE] = bus_wake_interrupt_enable;
      end
      `ADDR_INTERRUPT_FLAG: begin
        rd_data[`BIT_BUS_EDGE_FLAG] = bus_falling_edge_flag;
      end
      `ADDR_RESET_MASK: begin
        rd_data[`BIT_OVERTEMP_TEST] = overtemp_threshold_test;
        rd_data[`BIT_OVERVOLT_RE] = overvoltage_reset_enable;
        rd_data[`BIT_OVERTEMP_RE] = overtemp_reset_enable;
      end
      `ADDR_DIAG_MUX: rd_data[`MUX_SEL_HI:0] = mux_select; // R16
      `ADDR_POWER_OUTPUT: begin
        rd_data[`BIT_CS_ON] = current_source_on;
        rd_data[`BIT_CS_LEVEL_HI:`BIT_CS_LEVEL_LO] = current_level_sel;
      end
      `ADDR_SYSTEM_STATUS: rd_data = status_byte;
      default: rd_data = `REG_RESET;
    endcase
  end

  // -------------------------------------------------------------------------
  // Reset pin
  // -------------------------------------------------------------------------
  logic reset_request;

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= (overvolt_s & overvoltage_reset_enable) | // R1
                       (overtemp_s & overtemp_reset_enable); // R5
    end
  end

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = ~reset_request; // R1
  assign overtemp_low_threshold = overtemp_threshold_test; // R6

  // -------------------------------------------------------------------------
  // Bus transceiver
  // -------------------------------------------------------------------------
  logic tx_enable;

  assign tx_enable = supply_on & ~stop_s; // R7 R13
  assign lin_out = 1'b0;

  // The transmit input syncs to high after reset and is treated as high
  // until driven, so an absent host leaves the bus recessive.
  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      lin_oe_n <= 1'b1; // R11
      rxd <= 1'b1;
    end else begin
      lin_oe_n <= ~(tx_enable & ~txd_s); // R10
      rxd <= lin_s; // R12
    end
  end

  // -------------------------------------------------------------------------
  // Diagnostic multiplexer and current source
  // -------------------------------------------------------------------------
  genvar ch;
  for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
    always_ff @(posedge ref_clk) begin
      if (logic_rst) begin
        diag_channel_en[ch] <= 1'b0;
      end else begin
        diag_channel_en[ch] <= mux_select == 4'(ch) &&
                               3'(ch) != `MUX_CODE_UNUSED; // R15 R22
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (logic_rst) begin
      current_source_en <= 1'b0;
      current_source_pct <= `CS_PCT_00;
    end else begin
      current_source_en <= supply_on & current_source_on & ~stop_s; // R17 R19
      unique case (current_level_sel)
        2'h0: current_source_pct <= `CS_PCT_00; // R18
        2'h1: current_source_pct <= `CS_PCT_01; // R18
        2'h2: current_source_pct <= `CS_PCT_10; // R18
        2'h3: current_source_pct <= `CS_PCT_11; // R18
      endcase
    end
  end
endmodule : analog_die_ctrl

// [testbench/analog_die_ctrl_asserts.sv]
// Port-level checks of the analog die control block.
`timescale 1ns/1ps
module analog_die_ctrl_asserts #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rst_pin_in,
  input wire logic rst_pin_oe_n,
  input wire logic supply_overvoltage,
  input wire logic overtemp,
  input wire logic stop_mode,
  input wire logic txd,
  input wire logic rxd,
  input wire logic lin_in,
  input wire logic lin_oe_n,
  input wire logic lin_wake_irq,
  input wire logic regulator_wake,
  input wire logic [CHANNELS-1:0] diag_channel_en,
  input wire logic current_source_en,
  input wire logic [6:0] current_source_pct
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_pull;
    !rst_pin_oe_n |-> $past(supply_overvoltage, 3) || $past(overtemp, 3);
  endproperty
  a_pull: assert property (p_pull)
    else $error("reset pin pulled without a source");
  property p_hold_off;
    $rose(rst_pin_oe_n) |-> ##1 rst_pin_oe_n [*8];
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("reset source active again after reset");
  // The pin needs its synchroniser before the logic sees it, hence five.
  property p_pin_reset;
    !rst_pin_in [*5] |-> lin_oe_n && !current_source_en
      && diag_channel_en == '0;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("outputs not reset by the reset pin");
  property p_tx_release;
    txd [*4] |-> lin_oe_n;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("bus driven while transmit input high");
  property p_rx_follow;
    $fell(lin_in) |-> ##[2:3] !rxd;
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("receive output missed a dominant bus");
  property p_tx_stop;
    stop_mode [*4] |-> lin_oe_n;
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("bus driven in stop mode");
  property p_wake;
    lin_wake_irq == regulator_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request and regulator wake disagree");
  property p_mux;
    $onehot0(diag_channel_en) && !diag_channel_en[6];
  endproperty
  a_mux: assert property (p_mux)
    else $error("diagnostic routing not one source");
  property p_level;
    current_source_pct inside {7'h0a, 7'h1e, 7'h3c, 7'h64};
  endproperty
  a_level: assert property (p_level)
    else $error("current source level outside table");
  property p_cs_stop;
    stop_mode [*4] |-> !current_source_en;
  endproperty
  a_cs_stop: assert property (p_cs_stop)
    else $error("current source on in stop mode");
endmodule : analog_die_ctrl_asserts

bind analog_die_ctrl analog_die_ctrl_asserts #(.CHANNELS(CHANNELS))
  analog_die_ctrl_asserts_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .rst_pin_in(rst_pin_in),
  .rst_pin_oe_n(rst_pin_oe_n),
  .supply_overvoltage(supply_overvoltage),
  .overtemp(overtemp),
  .stop_mode(stop_mode),
  .txd(txd),
  .rxd(rxd),
  .lin_in(lin_in),
  .lin_oe_n(lin_oe_n),
  .lin_wake_irq(lin_wake_irq),
  .regulator_wake(regulator_wake),
  .diag_channel_en(diag_channel_en),
  .current_source_en(current_source_en),
  .current_source_pct(current_source_pct)
);

// [testbench/mcu_spi_master.sv]
// Microcontroller model that runs register frames on the serial link.
`timescale 1ns/1ps
module mcu_spi_master (
  input wire logic ref_clk,
  input wire logic spi_miso,
  output logic spi_ss_n,
  output logic spi_sclk,
  output logic spi_mosi
);
  // --------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------
  initial begin
    spi_ss_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // Four cycles per level keeps the slave's pin synchronisers in step.
  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat,
                       output logic [15:0] rx);
    logic [15:0] tx;
    tx = {hdr, dat};
    @(posedge ref_clk);
    #1 spi_ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (4) @(posedge ref_clk);
      #1 spi_sclk = 1'b1;
      rx[i] = spi_miso;
      repeat (4) @(posedge ref_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    #1 spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : frame
endmodule : mcu_spi_master

// [testbench/tb_analog_die_ctrl.sv]
// Self-checking bench for the analog die control block.
`timescale 1ns/1ps
module tb_analog_die_ctrl;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ss_n, sclk, mosi, miso, rst_pin_oe_n, low_thr, rxd, lin_oe_n;
  logic rst_drv, lin_drv;
  logic host_rst_n = 1'b1;
  logic ov = 1'b0;
  logic ot = 1'b0;
  logic stop = 1'b0;
  logic txd_en = 1'b0;
  logic txd_lvl = 1'b1;
  logic bus_other = 1'b1;
  logic lim = 1'b0;
  logic irq, wake, cs_en;
  logic [7:0] diag;
  logic [6:0] pct;
  logic [7:0] lvls [4] = '{8'h0a, 8'h1e, 8'h3c, 8'h64};
  int fails = 0;
  int checks = 0;
  // Reset pin and bus are pulled up; transmit input idles high.
  wire logic rst_pin = (rst_pin_oe_n | rst_drv) & host_rst_n;
  wire logic txd = txd_en ? txd_lvl : 1'b1;
  wire logic lin = (lin_oe_n | lin_drv) & bus_other;
  always #25 ref_clk = ~ref_clk;

  analog_die_ctrl #(.CHANNELS(8)) analog_die_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .spi_ss_n(ss_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso), .rst_pin_in(rst_pin),
    .rst_pin_out(rst_drv), .rst_pin_oe_n(rst_pin_oe_n),
    .supply_overvoltage(ov), .overtemp(ot),
    .overtemp_low_threshold(low_thr), .stop_mode(stop), .txd(txd),
    .rxd(rxd), .lin_in(lin), .lin_out(lin_drv), .lin_oe_n(lin_oe_n),
    .lin_current_limit(lim), .lin_wake_irq(irq), .regulator_wake(wake),
    .diag_channel_en(diag), .current_source_en(cs_en),
    .current_source_pct(pct));
  mcu_spi_master mcu_spi_master_inst (.ref_clk(ref_clk), .spi_miso(miso),
    .spi_ss_n(ss_n), .spi_sclk(sclk), .spi_mosi(mosi));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic test_done;
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] rx;
    mcu_spi_master_inst.frame({1'b0, a, ^a, 1'b0}, d, rx);
  endtask : wr
  task automatic rchk(input string what, input logic [4:0] a,
                      input logic [7:0] exp);
    logic [15:0] rx;
    mcu_spi_master_inst.frame({1'b1, a, ~^a, 1'b0}, 8'h00, rx);
    chk(what, exp, rx[7:0]);
  endtask : rchk
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (rst_pin_oe_n !== lvl && n < 200) begin
      tick(1);
      n++;
    end
    chk("reset pin", 8'(lvl), 8'(rst_pin_oe_n));
    if (rst_pin_oe_n !== lvl) test_done();
  endtask : wait_pin

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    rchk("reset mask", 5'h06, 8'h00);
    rchk("mux select", 5'h07, 8'h00);
    chk("mux channel", 8'h01, diag);
    chk("bus idle", 8'h01, 8'(lin_oe_n));
  endtask : t_reset
  task automatic t_regs;
    wr(5'h06, 8'hff);
    rchk("reset mask", 5'h06, 8'h83);
    chk("low threshold", 8'h01, 8'(low_thr));
    wr(5'h06, 8'h00);
    chk("low threshold", 8'h00, 8'(low_thr));
    for (int c = 0; c < 16; c++) begin
      wr(5'h07, 8'(c) | 8'hf0);
      rchk("mux select", 5'h07, 8'(c));
      chk("mux channel", (c < 8 && c != 6) ? 8'h01 << c : 8'h00, diag);
    end
    rchk("unmapped", 5'h1f, 8'h00);
  endtask : t_regs
  task automatic t_lin;
    txd_en = 1'b1;
    txd_lvl = 1'b0;
    tick(6);
    chk("driver off", 8'h01, 8'(lin_oe_n));
    wr(5'h03, 8'h80);
    chk("dominant", 8'h00, 8'(lin_oe_n));
    chk("receive", 8'h00, 8'(rxd));
    lim = 1'b1;
    rchk("status", 5'h0c, 8'h40);
    wr(5'h03, 8'h00);
    lim = 1'b0;
    chk("driver off", 8'h01, 8'(lin_oe_n));
    wr(5'h03, 8'h80);
    stop = 1'b1;
    tick(6);
    chk("stop driver", 8'h01, 8'(lin_oe_n));
    txd_en = 1'b0;
    tick(6);
    chk("receive", 8'h01, 8'(rxd));
  endtask : t_lin
  task automatic t_wake;
    wr(5'h05, 8'h20);
    wr(5'h04, 8'h20);
    chk("wake", 8'h00, 8'(irq));
    bus_other = 1'b0;
    tick(8);
    chk("receive", 8'h00, 8'(rxd));
    chk("wake", 8'h01, 8'(irq));
    chk("regulator", 8'h01, 8'(wake));
    bus_other = 1'b1;
    wr(5'h05, 8'h00);
    rchk("edge flag", 5'h05, 8'h20);
    wr(5'h05, 8'h20);
    rchk("edge flag", 5'h05, 8'h00);
    chk("wake", 8'h00, 8'(irq));
    stop = 1'b0;
  endtask : t_wake
  task automatic t_cs;
    for (int l = 0; l < 4; l++) begin
      wr(5'h0b, 8'h04 | 8'(l << 4));
      chk("source on", 8'h01, 8'(cs_en));
      chk("source level", lvls[l], 8'(pct));
    end
    stop = 1'b1;
    tick(6);
    chk("source stop", 8'h00, 8'(cs_en));
    stop = 1'b0;
    wr(5'h03, 8'h00);
    chk("source supply", 8'h00, 8'(cs_en));
  endtask : t_cs
  task automatic t_rst;
    ov = 1'b1;
    ot = 1'b1;
    tick(10);
    chk("masked source", 8'h01, 8'(rst_pin_oe_n));
    ot = 1'b0;
    // The self reset pulse lasts only a few cycles, so watch during the frame.
    fork
      wr(5'h06, 8'h02);
      wait_pin(1'b0);
    join
    wait_pin(1'b1);
    tick(10);
    chk("after reset", 8'h01, 8'(rst_pin_oe_n));
    ov = 1'b0;
    rchk("reset mask", 5'h06, 8'h00);
    wr(5'h07, 8'h05);
    host_rst_n = 1'b0;
    tick(6);
    host_rst_n = 1'b1;
    tick(5);
    rchk("mux select", 5'h07, 8'h00);
  endtask : t_rst

  initial begin
    tick(10);
    rst = 1'b0;
    tick(4);
    t_reset();
    t_regs();
    t_lin();
    t_wake();
    t_cs();
    t_rst();
    test_done();
  end
endmodule : tb_analog_die_ctrl
